// *** logic/sfs_pkg.sv ***
package sfs_pkg;
   localparam logic [11:0] SFS_CTRL_OFS = 12'h000;
   localparam logic [11:0] SFS_DATA_OFS = 12'h004;
   localparam logic [11:0] SFS_STAT_OFS = 12'h008;

   // control word, bit 0 is the enable
   typedef struct packed {
      logic [7:0] half_div;
      logic [3:0] dsize;
      logic cpha;
      logic cpol;
      logic slave;
      logic en;
   } sfs_ctrl_s;

   typedef struct packed {
      logic busy;
      logic rx_valid;
      logic tx_full;
   } sfs_stat_s;

   localparam logic [3:0] SFS_DSIZE_MIN = 4'h3;
   localparam logic [15:0] SFS_CTRL_RST = 16'h0070;
   localparam logic [2:0] SFS_SYNC_RST = 3'h2;

   typedef enum logic [1:0] {
      SFS_IDLE = 2'b00,
      SFS_LEAD = 2'b01,
      SFS_SHIFT = 2'b10,
      SFS_TAIL = 2'b11
   } sfs_state_e;
endpackage : sfs_pkg

// *** logic/sfs_frame_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_frame_seq
   import sfs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_clock_line_i,
   output logic serial_clock_line_o,
   output logic serial_clock_line_oe,
   input wire logic frame_select_line_i,
   output logic frame_select_line_o,
   output logic frame_select_line_oe,
   output logic serial_transmit_line_o,
   output logic serial_transmit_line_oe,
   input wire logic serial_receive_line_i
);

   function automatic logic bit_at(input logic [15:0] w, input logic [3:0] top);
      return w[top];
   endfunction : bit_at

   function automatic logic is_sample(input logic odd_edge, input logic cpha);
      return odd_edge ^ cpha;
   endfunction : is_sample

   function automatic logic [15:0] mask_word(input logic [15:0] w, input logic [3:0] top);
      logic [15:0] m;
      m = 16'hffff >> (4'hf - top);
      return w & m;
   endfunction : mask_word

   function automatic logic [5:0] edge_total(input logic [3:0] top);
      logic [4:0] n;
      n = {1'b0, top} + 5'h01;
      return {n, 1'b0};
   endfunction : edge_total

   sfs_ctrl_s ctrl_q;
   sfs_state_e st_q;
   logic [15:0] tx_data_q;
   logic tx_valid_q;
   logic [15:0] rx_data_q;
   logic rx_valid_q;
   logic rx_stb_q;
   logic [31:0] prdata_q;
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic sclk_prev_q;
   logic fss_prev_q;
   logic [7:0] cnt_q;
   logic [5:0] edg_q;
   logic [3:0] bits_q;
   logic [15:0] sh_q;
   logic [15:0] rsh_q;
   logic sclk_q;
   logic fss_q;
   logic tx_q;
   logic txoe_q;

   logic sclk_s;
   logic fss_s;
   logic rx_s;
   logic tick;
   logic [5:0] nedge;
   logic m_samp;
   logic m_last;
   logic m_done;
   logic m_chain;
   logic s_edge;
   logic s_fall;
   logic s_samp;
   logic s_last;
   logic take;
   logic [15:0] load_word;
   logic [15:0] rx_next;
   logic wr_acc;
   logic rd_acc;
   logic hit;

   assign sclk_s = sync_q[2];
   assign fss_s = sync_q[1];
   assign rx_s = sync_q[0];

   // pins: two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= SFS_SYNC_RST;
         sync_q <= SFS_SYNC_RST;
         sclk_prev_q <= 1'b0;
         fss_prev_q <= 1'b1;
      end else if (ce) begin
         meta_q <= {serial_clock_line_i, frame_select_line_i, serial_receive_line_i};
         sync_q <= meta_q;
         sclk_prev_q <= sync_q[2];
         fss_prev_q <= sync_q[1];
      end
   end

   always_comb begin
      tick = (cnt_q == 8'h00);
      nedge = edg_q + 6'h01;
      m_samp = is_sample(nedge[0], ctrl_q.cpha);
      m_last = (nedge == edge_total(ctrl_q.dsize));
      m_done = m_samp && ((nedge + {5'h00, ~ctrl_q.cpha}) == edge_total(ctrl_q.dsize));
      m_chain = m_last && ctrl_q.cpha && tx_valid_q && ctrl_q.en;
      s_edge = (sclk_s != sclk_prev_q) && !fss_s;
      s_fall = fss_prev_q && !fss_s;
      s_samp = s_edge && is_sample(sclk_s != ctrl_q.cpol, ctrl_q.cpha);
      s_last = s_samp && (bits_q == ctrl_q.dsize);
      load_word = tx_valid_q ? tx_data_q : 16'h0000;
      rx_next = mask_word({rsh_q[14:0], ctrl_q.slave ? rx_s : rx_s}, ctrl_q.dsize);
      take = 1'b0;
      if (ctrl_q.en && !ctrl_q.slave) begin
         if (st_q == SFS_IDLE) begin
            take = tx_valid_q;
         end else if (st_q == SFS_SHIFT && tick) begin
            take = m_chain;
         end
      end else if (ctrl_q.en && ctrl_q.slave && tx_valid_q) begin
         take = s_fall || (s_last && ctrl_q.cpha);
      end
   end

   // serial sequencer, master and slave
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= SFS_IDLE;
         cnt_q <= 8'h00;
         edg_q <= 6'h00;
         bits_q <= 4'h0;
         sh_q <= 16'h0000;
         rsh_q <= 16'h0000;
         rx_data_q <= 16'h0000;
         rx_stb_q <= 1'b0;
         sclk_q <= 1'b0;
         fss_q <= 1'b1;
         tx_q <= 1'b0;
         txoe_q <= 1'b0;
      end else if (ce) begin
         rx_stb_q <= 1'b0;
         if (!ctrl_q.en || ctrl_q.slave) begin
            st_q <= SFS_IDLE;
            sclk_q <= ctrl_q.cpol;
            fss_q <= 1'b1;
            if (!ctrl_q.en || fss_s) begin
               tx_q <= 1'b0;
               txoe_q <= 1'b0;
               bits_q <= 4'h0;
            end else if (s_fall) begin
               txoe_q <= 1'b1;
               bits_q <= 4'h0;
               if (!ctrl_q.cpha) begin
                  tx_q <= bit_at(load_word, ctrl_q.dsize);
                  sh_q <= load_word << 1;
               end else begin
                  sh_q <= load_word;
               end
            end else if (s_samp) begin
               rsh_q <= {rsh_q[14:0], rx_s};
               if (s_last) begin
                  bits_q <= 4'h0;
                  rx_data_q <= rx_next;
                  rx_stb_q <= 1'b1;
                  if (ctrl_q.cpha) begin
                     sh_q <= load_word;
                  end
               end else begin
                  bits_q <= bits_q + 4'h1;
               end
            end else if (s_edge) begin
               tx_q <= bit_at(sh_q, ctrl_q.dsize);
               sh_q <= sh_q << 1;
            end
         end else begin
            unique case (st_q)
               SFS_IDLE: begin
                  sclk_q <= ctrl_q.cpol;
                  fss_q <= 1'b1;
                  tx_q <= 1'b0;
                  if (tx_valid_q) begin
                     sh_q <= tx_data_q;
                     fss_q <= 1'b0;
                     txoe_q <= 1'b1;
                     cnt_q <= ctrl_q.half_div;
                     edg_q <= 6'h00;
                     st_q <= SFS_LEAD;
                  end else begin
                     txoe_q <= 1'b0;
                  end
               end
               SFS_LEAD: begin
                  if (tick) begin
                     cnt_q <= ctrl_q.half_div;
                     st_q <= SFS_SHIFT;
                     tx_q <= bit_at(sh_q, ctrl_q.dsize);
                     sh_q <= sh_q << 1;
                     if (ctrl_q.cpha) begin
                        sclk_q <= ~sclk_q;
                        edg_q <= 6'h01;
                     end else begin
                        edg_q <= 6'h00;
                     end
                  end else begin
                     cnt_q <= cnt_q - 8'h01;
                  end
               end
               SFS_SHIFT: begin
                  if (tick) begin
                     cnt_q <= ctrl_q.half_div;
                     sclk_q <= ~sclk_q;
                     edg_q <= nedge;
                     if (m_samp) begin
                        rsh_q <= {rsh_q[14:0], rx_s};
                        if (m_done) begin
                           rx_data_q <= rx_next;
                           rx_stb_q <= 1'b1;
                        end
                     end else if (!m_last) begin
                        tx_q <= bit_at(sh_q, ctrl_q.dsize);
                        sh_q <= sh_q << 1;
                     end
                     if (m_chain) begin
                        sh_q <= tx_data_q;
                        edg_q <= 6'h00;
                        st_q <= SFS_LEAD;
                     end else if (m_last) begin
                        edg_q <= 6'h00;
                        st_q <= SFS_TAIL;
                     end
                  end else begin
                     cnt_q <= cnt_q - 8'h01;
                  end
               end
               SFS_TAIL: begin
                  if (tick) begin
                     cnt_q <= ctrl_q.half_div;
                     if (edg_q == {5'h00, ctrl_q.cpha}) begin
                        fss_q <= 1'b1;
                        tx_q <= 1'b0;
                        txoe_q <= 1'b0;
                        st_q <= SFS_IDLE;
                     end else begin
                        edg_q <= nedge;
                     end
                  end else begin
                     cnt_q <= cnt_q - 8'h01;
                  end
               end
            endcase
         end
      end
   end

   assign hit = (paddr == SFS_CTRL_OFS) || (paddr == SFS_DATA_OFS) || (paddr == SFS_STAT_OFS);
   assign wr_acc = psel && penable && pwrite && hit;
   assign rd_acc = psel && penable && !pwrite && (paddr == SFS_DATA_OFS);

   // register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= sfs_ctrl_s'(SFS_CTRL_RST);
         tx_data_q <= 16'h0000;
         tx_valid_q <= 1'b0;
         rx_valid_q <= 1'b0;
      end else if (ce) begin
         if (wr_acc && paddr == SFS_CTRL_OFS) begin
            ctrl_q <= sfs_ctrl_s'(pwdata[15:0]);
            if (pwdata[7:4] < SFS_DSIZE_MIN) begin
               ctrl_q.dsize <= SFS_DSIZE_MIN;
            end
         end
         if (wr_acc && paddr == SFS_DATA_OFS && (!tx_valid_q || take)) begin
            tx_data_q <= pwdata[15:0];
            tx_valid_q <= 1'b1;
         end else if (take) begin
            tx_valid_q <= 1'b0;
         end
         if (rx_stb_q) begin
            rx_valid_q <= 1'b1;
         end else if (rd_acc) begin
            rx_valid_q <= 1'b0;
         end
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         if (paddr == SFS_CTRL_OFS) begin
            prdata_q <= {16'h0000, ctrl_q};
         end else if (paddr == SFS_DATA_OFS) begin
            prdata_q <= {16'h0000, rx_data_q};
         end else if (paddr == SFS_STAT_OFS) begin
            prdata_q <= {29'h0000_0000, sfs_stat_s'({st_q != SFS_IDLE || txoe_q,
                                                    rx_valid_q, tx_valid_q})};
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign serial_clock_line_o = sclk_q;
   assign serial_clock_line_oe = !ctrl_q.slave;
   assign frame_select_line_o = fss_q;
   assign frame_select_line_oe = !ctrl_q.slave;
   assign serial_transmit_line_o = tx_q;
   assign serial_transmit_line_oe = txoe_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   idle_clk_low_a: assert property (
      (st_q == SFS_IDLE && !ctrl_q.cpol && $past(!ctrl_q.cpol) && $past(ctrl_q.en)
       && !ctrl_q.slave) |-> !sclk_q)
      else $error("serial clock not low while idle");
   idle_clk_high_a: assert property (
      (st_q == SFS_IDLE && ctrl_q.cpol && $past(ctrl_q.cpol) && $past(st_q) == SFS_IDLE)
      |-> sclk_q)
      else $error("serial clock not high while idle");
   idle_select_a: assert property (
      (st_q == SFS_IDLE && $past(st_q) == SFS_IDLE) |-> fss_q)
      else $error("frame select low while idle");
   idle_tx_low_a: assert property (
      (!ctrl_q.slave && st_q == SFS_IDLE && $past(st_q) == SFS_IDLE) |-> !tx_q)
      else $error("transmit line high while idle");
   clock_pad_a: assert property (
      (st_q != SFS_IDLE) |-> serial_clock_line_oe)
      else $error("clock pad off during master frame");
   slave_pad_a: assert property (
      (ctrl_q.slave && $past(ctrl_q.slave)) |-> !serial_clock_line_oe && fss_q)
      else $error("slave drives clock pad");
   frame_start_a: assert property (
      $fell(fss_q) |-> $past(tx_valid_q && ctrl_q.en && !ctrl_q.slave) && txoe_q)
      else $error("frame started without data or driver");
   no_toggle_a: assert property (
      (ce && $past(ce) && st_q == SFS_IDLE && $past(st_q) == SFS_IDLE
       && $stable(ctrl_q.cpol) && $past(ctrl_q.cpol) == $past(ctrl_q.cpol, 2))
      |-> $stable(sclk_q))
      else $error("serial clock toggled outside frame");
   lead_hold_a: assert property (
      (ce && st_q == SFS_LEAD && !ctrl_q.cpha && tick) |=> $stable(sclk_q) && !fss_q)
      else $error("clock moved with first data bit");
   burst_select_a: assert property (
      (ce && st_q == SFS_SHIFT && tick && m_chain) |=> !fss_q && st_q == SFS_LEAD)
      else $error("select left low burst");
   tail_release_a: assert property (
      ($past(st_q) == SFS_TAIL && st_q == SFS_IDLE) |-> fss_q && !txoe_q && !tx_q)
      else $error("select not released after last word");
   word_gap_a: assert property (
      (ce && ctrl_q.en && !ctrl_q.slave && !ctrl_q.cpha && st_q == SFS_SHIFT
       && tick && m_last) |=> st_q == SFS_TAIL)
      else $error("phase low word chained without select gap");

   master_word_c: cover property (st_q == SFS_TAIL ##1 st_q == SFS_IDLE);
   burst_chain_c: cover property (st_q == SFS_SHIFT ##1 st_q == SFS_LEAD);
   slave_word_c: cover property (ctrl_q.slave && rx_stb_q);
   abort_c: cover property (st_q != SFS_IDLE && !ctrl_q.en);
endmodule : sfs_frame_seq
`default_nettype wire

// *** dv/sfs_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfs_slave_model (
   input wire logic sclk,
   input wire logic fss_n,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [4:0] nbits,
   input wire logic [15:0] tx_word,
   output logic miso,
   output logic [15:0] rx_word,
   output logic done_t
);
   logic [15:0] sh;
   logic [15:0] rx;
   int idx;
   initial begin
      miso = 1'b0;
      done_t = 1'b0;
      rx_word = 16'h0;
      idx = 0;
   end
   // word loaded at select fall and after each completed word; phase low shows msb at select fall
   always @(negedge fss_n) begin
      sh = tx_word;
      idx = 0;
      rx = 16'h0;
      if (!cpha) miso = sh[nbits - 1];
   end
   // released line shows the inverse of its last value
   always @(posedge fss_n) miso = !miso;
   // capture edge where sclk^cpol^cpha is high, msb first
   always @(sclk) begin
      if (fss_n === 1'b0 && (sclk ^ cpol ^ cpha) === 1'b1) begin
         rx = {rx[14:0], mosi};
         idx++;
         if (idx == nbits) begin
            rx_word = rx;
            done_t = !done_t;
            idx = 0;
            sh = tx_word;
            rx = 16'h0;
         end
      end else if (fss_n === 1'b0) begin
         miso = sh[nbits - 1 - idx];
      end
   end
endmodule : sfs_slave_model
`default_nettype wire

// *** dv/test_spi_frame_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_spi_frame_sequencer
   import sfs_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, w;
   logic sclk_o, sclk_oe, fss_o, fss_oe, tx_o, tx_oe, miso, done_t;
   logic sclk_b, fss_b, mosi_b, role, cpol, cpha, ps, pf, ce;
   logic [15:0] rx_word, slv_tx, mask;
   logic [4:0] nbits;
   logic [32:0] rd_got;
   logic [32:0] rq[$];
   logic [15:0] sq[$];
   sfs_ctrl_s c;
   int bad_count, num_checks, cyc, tog, rises, wc;
   integer seed;
   event rd_ev;
   wire logic sclk_w = sclk_oe ? sclk_o : sclk_b;
   wire logic fss_w = fss_oe ? fss_o : fss_b;
   wire logic tx_w = tx_oe ? tx_o : ~tx_o;
   wire logic rx_w = role ? mosi_b : miso;

   sfs_frame_seq dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clock_line_i(sclk_w), .serial_clock_line_o(sclk_o),
      .serial_clock_line_oe(sclk_oe), .frame_select_line_i(fss_w),
      .frame_select_line_o(fss_o), .frame_select_line_oe(fss_oe),
      .serial_transmit_line_o(tx_o), .serial_transmit_line_oe(tx_oe),
      .serial_receive_line_i(rx_w));
   sfs_slave_model slv (.sclk(sclk_w), .fss_n(fss_w), .mosi(tx_w), .cpol(cpol),
      .cpha(cpha), .nbits(nbits), .tx_word(slv_tx), .miso(miso), .rx_word(rx_word),
      .done_t(done_t));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input string what, input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results

   task automatic apb(input logic wr_n, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_n;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_got = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
      ->rd_ev;
   endtask : rd

   task automatic idle_chk;
      check("sclk idle", sclk_o, cpol);
      check("fss idle", fss_o, 1'b1);
      check("tx idle", tx_o, 1'b0);
      check("sclk oe", sclk_oe, !role);
      check("fss oe", fss_oe, !role);
   endtask : idle_chk

   always @(rd_ev) check("read", rd_got, rq.pop_front());
   always @(done_t) begin
      if (sq.size() > 0) begin
         wc++;
         check("slave rx", rx_word, sq.pop_front());
      end
   end

   always @(negedge pclk) begin
      cyc++;
      if (sclk_o !== ps) tog++;
      if (fss_o === 1'b1 && pf === 1'b0) rises++;
      if (fss_o === 1'b0 && pf === 1'b1 && !role) check("tx oe", tx_oe, 1'b1);
      ps = sclk_o;
      pf = fss_o;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      int k, m;
      seed = 32'h3561;
      presetn = 1'b0;
      {psel, penable, pwrite, sclk_b, mosi_b, role, cpol, cpha} = 8'h00;
      ce = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      fss_b = 1'b1;
      nbits = 5'h08;
      slv_tx = 16'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(SFS_CTRL_OFS, {17'h0, SFS_CTRL_RST});
      rd(SFS_STAT_OFS, 33'h0);
      rd(12'h0fc, {1'b1, 32'h0});
      idle_chk();
      wr(SFS_DATA_OFS, 32'h00a5);
      repeat (20) @(posedge pclk);
      check("no start", fss_o, 1'b1);
      c = SFS_CTRL_RST;
      c.en = 1'b1;
      wr(SFS_CTRL_OFS, {16'h0, c});
      for (k = 0; k < 50 && fss_o !== 1'b0; k++) @(posedge pclk);
      check("start", fss_o, 1'b0);
      repeat (12) @(posedge pclk);
      c.en = 1'b0;
      wr(SFS_CTRL_OFS, {16'h0, c});
      repeat (2) @(posedge pclk);
      idle_chk();
      for (m = 0; m < 4; m++) begin
         c = '0;
         c.half_div = 8'h03;
         c.dsize = 4'(3 + ($random(seed) & 32'hff) % 13);
         {c.cpol, c.cpha} = m[1:0];
         c.en = 1'b1;
         {cpol, cpha} = m[1:0];
         nbits = {1'b0, c.dsize} + 5'h01;
         mask = 16'((32'h1 << nbits) - 32'h1);
         slv_tx = 16'($random(seed));
         wr(SFS_CTRL_OFS, {16'h0, c});
         repeat (4) @(posedge pclk);
         idle_chk();
         tog = 0;
         rises = 0;
         wc = 0;
         for (k = 0; k < 2; k++) begin
            w = $random(seed);
            sq.push_back(w[15:0] & mask);
            wr(SFS_DATA_OFS, w);
            for (int j = 0; j < 500 && fss_o !== 1'b0; j++) @(posedge pclk);
         end
         if (m == 1) begin
            ce <= 1'b0;
            repeat (6) @(posedge pclk);
            ce <= 1'b1;
         end
         for (k = 0; k < 3000 && !(wc == 2 && fss_o === 1'b1); k++) @(posedge pclk);
         repeat (4) @(posedge pclk);
         check("slave words", 32'(wc), 33'h2);
         check("sclk edges", 32'(tog), 32'(4 * nbits));
         check("fss rises", 32'(rises), cpha ? 33'h1 : 33'h2);
         rd(SFS_DATA_OFS, {17'h0, slv_tx & mask});
      end
      role <= 1'b1;
      c = '0;
      c.dsize = 4'h7;
      c.slave = 1'b1;
      c.en = 1'b1;
      {cpol, cpha} = 2'b00;
      wr(SFS_CTRL_OFS, {16'h0, c});
      repeat (4) @(posedge pclk);
      idle_chk();
      wr(SFS_DATA_OFS, {16'h0, slv_tx});
      w = $random(seed);
      fss_b <= 1'b0;
      repeat (4) @(posedge pclk);
      for (k = 7; k >= 0; k--) begin
         mosi_b <= w[k];
         repeat (4) @(posedge pclk);
         check("slave tx", tx_o, slv_tx[k]);
         sclk_b <= 1'b1;
         repeat (4) @(posedge pclk);
         sclk_b <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      fss_b <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(SFS_DATA_OFS, {25'h0, w[7:0]});
      repeat (2) @(posedge pclk);
      results();
   end
endmodule : test_spi_frame_sequencer
`default_nettype wire
